// *** nicirq_pkg.sv ***
package nicirq_pkg;
  // ----------------------------------------------------------------
  // register select codes
  // ----------------------------------------------------------------
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_ENABLE = 3'h0; // interrupt_enable_mask
  localparam logic [2:0] SEL_STATUS = 3'h1; // interrupt_source_flags
  localparam logic [2:0] SEL_ACK = 3'h2; // source_flags_ack_view
  localparam logic [2:0] SEL_TXRES = 3'h3; // tx_result_reg
  localparam logic [2:0] SEL_CHIPCTL = 3'h4; // chip_control_reg

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int BIT_IRQ = 0;
  localparam int BIT_FATAL = 1;
  localparam int BIT_TXDONE = 2;
  localparam int BIT_CTLFRM = 3;
  localparam int BIT_RXARR = 4;
  localparam int BIT_SWIRQ = 6;
  localparam int BIT_STATS = 7;
  localparam int BIT_LINK = 8;
  localparam int BIT_TXDMA = 9;
  localparam int BIT_RXDMA = 10;
  localparam int BIT_LISTEND = 11;
  localparam int BIT_HIPRI = 12;
  localparam logic [15:0] SRC_MASK = 16'h1FDE; // bits 1-4 and 6-12
  localparam logic [15:0] W1C_MASK = 16'h1F48; // bits 3, 6, 8-12
  localparam int CTL_FULL_RESET = 0;
  localparam int CTL_HOST_RESET = 1;

  // ----------------------------------------------------------------
  // reset values and priority field width
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam int PRIO_W = 3;
endpackage : nicirq_pkg

// *** nicirq_status_enable.sv ***
module nicirq_status_enable (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [nicirq_pkg::SEL_W-1:0] regSel,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [nicirq_pkg::DATA_W-1:0] regWrData,
  output logic [nicirq_pkg::DATA_W-1:0] regRdData,
  input wire logic [nicirq_pkg::DATA_W-1:0] txResultData,
  input wire logic pciTargetAbort,
  input wire logic pciMasterAbort,
  input wire logic txSentOk,
  input wire logic txNotifyRequest,
  input wire logic txError,
  input wire logic macCtrlFrameRx,
  input wire logic rxWholeFrame,
  input wire logic rxEngineAck,
  input wire logic swIrqRequest,
  input wire logic statsNearFull,
  input wire logic statsAllRead,
  input wire logic phyLinkPin,
  input wire logic txDmaDone,
  input wire logic rxDmaDone,
  input wire logic rxListEnd,
  input wire logic rxTagValid,
  input wire logic [nicirq_pkg::PRIO_W-1:0] rxTagPriority,
  input wire logic [nicirq_pkg::PRIO_W-1:0] priorityLevelLimit,
  output logic busIrq
);
  import nicirq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] enableMask;
  logic [15:0] flags;
  logic [15:0] next_enableMask;
  logic [15:0] next_flags;
  logic next_busIrq;
  logic [15:0] next_regRdData;
  logic linkPrev;
  logic linkPrevValid;
  logic next_linkPrev;
  logic next_linkPrevValid;
  logic [15:0] setVec;
  logic [15:0] clrVec;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic wrEnable;
  logic wrStatus;
  logic wrChipCtl;
  logic rdAck;
  logic rdTxRes;
  assign wrEnable = regWr && (regSel == SEL_ENABLE);
  assign wrStatus = regWr && (regSel == SEL_STATUS);
  assign wrChipCtl = regWr && (regSel == SEL_CHIPCTL);
  assign rdAck = regRd && (regSel == SEL_ACK);
  assign rdTxRes = regRd && (regSel == SEL_TXRES);

  // any flag that passes its enable bit
  function automatic logic anyEnabled(input logic [15:0] f, input logic [15:0] m);
    return |(f & m);
  endfunction : anyEnabled

  // event set and acknowledge vectors
  always_comb begin
    setVec = 16'h0000;
    clrVec = 16'h0000;
    setVec[BIT_FATAL] = pciTargetAbort || pciMasterAbort;
    setVec[BIT_TXDONE] = (txSentOk && txNotifyRequest) || txError;
    setVec[BIT_CTLFRM] = macCtrlFrameRx;
    setVec[BIT_RXARR] = rxWholeFrame;
    setVec[BIT_SWIRQ] = swIrqRequest;
    setVec[BIT_STATS] = statsNearFull;
    setVec[BIT_LINK] = linkPrevValid && (phyLinkPin != linkPrev);
    setVec[BIT_TXDMA] = txDmaDone;
    setVec[BIT_RXDMA] = rxDmaDone;
    setVec[BIT_LISTEND] = rxListEnd;
    setVec[BIT_HIPRI] = rxTagValid && (rxTagPriority >= priorityLevelLimit);
    clrVec[BIT_FATAL] = wrChipCtl && regWrData[CTL_FULL_RESET]
                        && regWrData[CTL_HOST_RESET];
    clrVec[BIT_TXDONE] = rdTxRes;
    clrVec[BIT_RXARR] = rxEngineAck;
    clrVec[BIT_STATS] = statsAllRead;
    if (wrStatus) begin
      clrVec = clrVec | (regWrData & W1C_MASK);
    end
  end

  // next flag, mask, irq and read data
  always_comb begin
    next_flags = ((flags & ~clrVec) | setVec) & SRC_MASK;
    next_enableMask = enableMask;
    if (rdAck) begin
      next_enableMask = RST_ENABLE;
    end else if (wrEnable) begin
      next_enableMask = regWrData & SRC_MASK;
    end
    next_busIrq = anyEnabled(next_flags, next_enableMask);
    next_linkPrev = phyLinkPin;
    next_linkPrevValid = 1'b1;
    next_regRdData = regRdData;
    if (regRd) begin
      unique case (regSel)
        SEL_ENABLE: next_regRdData = enableMask;
        SEL_STATUS, SEL_ACK: next_regRdData = flags | {15'h0000, busIrq};
        SEL_TXRES: next_regRdData = txResultData;
        default: next_regRdData = 16'h0000;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags <= RST_FLAGS;
      enableMask <= RST_ENABLE;
      busIrq <= 1'b0;
      regRdData <= 16'h0000;
      linkPrev <= 1'b0;
      linkPrevValid <= 1'b0;
    end else begin
      flags <= next_flags;
      enableMask <= next_enableMask;
      busIrq <= next_busIrq;
      regRdData <= next_regRdData;
      linkPrev <= next_linkPrev;
      linkPrevValid <= next_linkPrevValid;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_irq_gating: assert property (busIrq == anyEnabled(flags, enableMask))
    else $error("bus interrupt does not match enabled flags");
  chk_ack_clears_mask: assert property (rdAck |=> enableMask == 16'h0000)
    else $error("enable mask not cleared by ack read");
  chk_mask_reserved: assert property (enableMask[0] == 1'b0 && enableMask[5] == 1'b0
                                      && enableMask[15:13] == 3'h0)
    else $error("reserved enable bit set");
  chk_status_irq_bit: assert property (regRd && regSel == SEL_STATUS
                                       |=> regRdData[0] == $past(busIrq))
    else $error("status bit 0 differs from bus interrupt");
  chk_fatal_set: assert property (pciTargetAbort || pciMasterAbort
                                  |=> flags[BIT_FATAL])
    else $error("abort did not set fatal flag");
  chk_fatal_holds: assert property (flags[BIT_FATAL] && !clrVec[BIT_FATAL]
                                    |=> flags[BIT_FATAL])
    else $error("fatal flag dropped without chip reset write");
  chk_txdone_clear: assert property (rdTxRes && !setVec[BIT_TXDONE]
                                     |=> !flags[BIT_TXDONE])
    else $error("tx result read did not clear tx done");
  chk_link_edge: assert property (linkPrevValid && $changed(phyLinkPin)
                                  |=> flags[BIT_LINK])
    else $error("link transition not flagged");
  chk_hipri_set: assert property (rxTagValid && rxTagPriority >= priorityLevelLimit
                                  |=> flags[BIT_HIPRI])
    else $error("high priority frame not flagged");
  chk_w1c_clear: assert property (wrStatus && regWrData[BIT_CTLFRM] && !macCtrlFrameRx
                                  |=> !flags[BIT_CTLFRM])
    else $error("write one did not clear control frame flag");

  // set, clear and read-path checks
  chk_txdone_set: assert property ((txSentOk && txNotifyRequest) || txError
                                   |=> flags[BIT_TXDONE])
    else $error("transmit event did not set tx done");
  chk_ctlfrm_set: assert property (macCtrlFrameRx |=> flags[BIT_CTLFRM])
    else $error("control frame did not set its flag");
  chk_rxarr_set: assert property (rxWholeFrame |=> flags[BIT_RXARR])
    else $error("whole frame did not set rx arrived");
  chk_rxarr_clear: assert property (rxEngineAck && !rxWholeFrame
                                    |=> !flags[BIT_RXARR])
    else $error("engine ack did not clear rx arrived");
  chk_link_w1c: assert property (wrStatus && regWrData[BIT_LINK] && !setVec[BIT_LINK]
                                 |=> !flags[BIT_LINK])
    else $error("write one did not clear link flag");
  chk_swirq_w1c: assert property (wrStatus && regWrData[BIT_SWIRQ] && !swIrqRequest
                                  |=> !flags[BIT_SWIRQ])
    else $error("write one did not clear software flag");
  chk_stats_set: assert property (statsNearFull |=> flags[BIT_STATS])
    else $error("near full did not set stats flag");
  chk_stats_clear: assert property (statsAllRead && !statsNearFull
                                    |=> !flags[BIT_STATS])
    else $error("reading all counters did not clear stats flag");
  chk_fatal_clear: assert property (clrVec[BIT_FATAL] && !setVec[BIT_FATAL]
                                    |=> !flags[BIT_FATAL])
    else $error("chip reset write did not clear fatal flag");
  chk_flags_sticky: assert property (!regWr && !rdTxRes && !rxEngineAck && !statsAllRead
                                     |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without acknowledge");
  chk_mask_write: assert property (wrEnable
                                   |=> enableMask == ($past(regWrData) & SRC_MASK))
    else $error("enable write not stored");
  chk_irq_masked: assert property (rdAck |=> !busIrq)
    else $error("bus interrupt after mask cleared");
  chk_rd_hold: assert property (!regRd |=> $stable(regRdData))
    else $error("read data changed without a read");
  chk_txres_data: assert property (rdTxRes |=> regRdData == $past(txResultData))
    else $error("tx result read returned wrong data");
endmodule : nicirq_status_enable

// *** nicirq_host_model.sv ***
module nicirq_host_model (
  input wire logic clk_sys,
  output logic [nicirq_pkg::SEL_W-1:0] regSel,
  output logic regWr,
  output logic regRd,
  output logic [nicirq_pkg::DATA_W-1:0] regWrData,
  input wire logic [nicirq_pkg::DATA_W-1:0] regRdData
);
  timeunit 1ns;
  timeprecision 100ps;
  import nicirq_pkg::*;
  // idle bus at time zero
  initial begin
    regSel = SEL_ENABLE;
    regWr = 1'b0;
    regRd = 1'b0;
    regWrData = 16'h0000;
  end
  // one write; enable writes keep reserved bits and the rx arrived bit (bit 4) at zero
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_sys) #1;
    regSel = s;
    regWrData = (s == SEL_ENABLE) ? (d & SRC_MASK & ~16'h0010) : d;
    regWr = 1'b1;
    @(posedge clk_sys) #1;
    regWr = 1'b0;
    regWrData = ~regWrData; // stale data no longer shown
  endtask : wr
  // one read; data registered at the read edge
  task automatic rd(input logic [2:0] s, output logic [15:0] d);
    @(posedge clk_sys) #1;
    regSel = s;
    regRd = 1'b1;
    @(posedge clk_sys) #1;
    regRd = 1'b0;
    d = regRdData;
  endtask : rd
endmodule : nicirq_host_model

// *** tb_nic_interrupt_status_enable.sv ***
module tb_nic_interrupt_status_enable;
  timeunit 1ns;
  timeprecision 100ps;
  import nicirq_pkg::*;
  logic clk_sys, rst_n, busIrq, linkPin, regWr, regRd;
  logic [2:0] regSel, tagPrio, prioLimit;
  logic [15:0] ev, rdData, regWrData, d;
  int nMismatch, cmpCount;
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  nicirq_status_enable dut (.clk_sys(clk_sys), .rst_n(rst_n), .regSel(regSel), .regWr(regWr),
    .regRd(regRd), .regWrData(regWrData), .regRdData(rdData), .txResultData(~ev),
    .pciTargetAbort(ev[1]), .pciMasterAbort(ev[0]), .txSentOk(ev[5]), .txNotifyRequest(ev[13]),
    .txError(ev[2]), .macCtrlFrameRx(ev[3]), .rxWholeFrame(ev[4]), .rxEngineAck(ev[14]),
    .swIrqRequest(ev[6]), .statsNearFull(ev[7]), .statsAllRead(ev[15]), .phyLinkPin(linkPin),
    .txDmaDone(ev[9]), .rxDmaDone(ev[10]), .rxListEnd(ev[11]), .rxTagValid(ev[12]),
    .rxTagPriority(tagPrio), .priorityLevelLimit(prioLimit), .busIrq(busIrq));
  nicirq_host_model host (.clk_sys(clk_sys), .regSel(regSel), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(rdData));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle event pulse on the selected inputs
  task automatic pulse(input logic [15:0] m);
    @(posedge clk_sys) #1;
    ev = m;
    @(posedge clk_sys) #1;
    ev = 16'h0000;
  endtask : pulse
  // each source except rx arrived (bit 4): masked, then enabled, then acknowledged
  task automatic t_sources();
    host.rd(SEL_STATUS, d);
    chk(d, RST_FLAGS);
    for (int b = 1; b <= 12; b++) begin
      if (b == 4 || b == 5) continue;
      host.wr(SEL_ENABLE, 16'h0000);
      if (b == BIT_LINK) linkPin = ~linkPin;
      else pulse(16'h0001 << b);
      chk({15'h0000, busIrq}, 16'h0000);
      host.rd(SEL_STATUS, d);
      chk(d, 16'h0001 << b);
      host.wr(SEL_ENABLE, 16'h0001 << b);
      chk({15'h0000, busIrq}, 16'h0001);
      host.rd(SEL_STATUS, d);
      chk(d, (16'h0001 << b) | 16'h0001);
      case (b)
        BIT_FATAL: host.wr(SEL_CHIPCTL, 16'h0003);
        BIT_TXDONE: host.rd(SEL_TXRES, d);
        BIT_STATS: pulse(16'h8000);
        default: host.wr(SEL_STATUS, 16'h0001 << b);
      endcase
      chk({15'h0000, busIrq}, 16'h0000);
    end
    $display("test sources done");
  endtask : t_sources
  // ack view read clears the mask, not the flag
  task automatic t_ack();
    host.wr(SEL_ENABLE, 16'h1FDE);
    pulse(16'h0040);
    host.rd(SEL_ACK, d);
    chk(d, 16'h0041);
    chk({15'h0000, busIrq}, 16'h0000);
    host.rd(SEL_ENABLE, d);
    chk(d, 16'h0000);
    host.rd(SEL_STATUS, d);
    chk(d, 16'h0040);
    host.wr(SEL_STATUS, 16'h0040);
    $display("test ack done");
  endtask : t_ack
  // partial clears and conditional sets
  task automatic t_misc();
    pulse(16'h0001);
    host.wr(SEL_CHIPCTL, 16'h0001);
    pulse(16'h0020);
    tagPrio = 3'h4;
    pulse(16'h1000);
    host.rd(SEL_STATUS, d);
    chk(d, 16'h0002);
    host.wr(SEL_CHIPCTL, 16'h0003);
    pulse(16'h2020);
    pulse(16'h0010);
    host.rd(SEL_STATUS, d);
    chk(d, 16'h0014);
    pulse(16'h4000);
    host.rd(SEL_TXRES, d);
    chk(d, 16'hFFFF);
    host.rd(SEL_STATUS, d);
    chk(d, 16'h0000);
    $display("test misc done");
  endtask : t_misc
  // set wins, lowered limit, then a reset in mid-run
  task automatic t_reset();
    prioLimit = 3'h4;
    pulse(16'h5050);
    host.rd(SEL_STATUS, d);
    chk(d, 16'h1050);
    host.wr(SEL_ENABLE, 16'h0040);
    chk({15'h0000, busIrq}, 16'h0001);
    @(posedge clk_sys) #1;
    rst_n = 1'b0;
    @(posedge clk_sys) #1;
    chk({15'h0000, busIrq}, 16'h0000);
    chk(rdData, 16'h0000);
    rst_n = 1'b1;
    host.rd(SEL_ENABLE, d);
    chk(d, RST_ENABLE);
    host.rd(SEL_STATUS, d);
    chk(d, RST_FLAGS);
    $display("test reset done");
  endtask : t_reset
  // counts and verdict
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // reset, then the scenarios
  initial begin
    rst_n = 1'b0;
    ev = 16'h0000;
    linkPin = 1'b0;
    tagPrio = 3'h5;
    prioLimit = 3'h5;
    nMismatch = 0;
    cmpCount = 0;
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_sources();
    t_ack();
    t_misc();
    t_reset();
    conclude();
  end
endmodule : tb_nic_interrupt_status_enable
